// file: design/ahpc_pkg.sv
// package: constants for the port command-flow host controller
package ahpc_pkg;
	// ------------------------------------------------------------
	// software-facing register offsets (apb byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_LBA_LO   = 8'h04;
	localparam logic [7:0]  REG_LBA_HI   = 8'h08;
	localparam logic [7:0]  REG_COUNT    = 8'h0C;
	localparam logic [7:0]  REG_BUF_ADDR = 8'h10;
	localparam logic [7:0]  REG_BYTE_CNT = 8'h14;
	localparam logic [7:0]  REG_STATUS   = 8'h18;
	// ------------------------------------------------------------
	// device-side map (port registers and command memories)
	// ------------------------------------------------------------
	localparam logic [31:0] DEV_HDR_BASE  = 32'h0000_0000;
	localparam int          DEV_HDR_SHIFT = 5;
	localparam logic [31:0] DEV_TBL_BASE  = 32'h0001_0000;
	localparam int          DEV_TBL_SHIFT = 11;
	localparam logic [31:0] DEV_PRD_OFS   = 32'h0000_0080;
	localparam logic [31:0] DEV_PX_IS     = 32'h0002_0010;
	localparam logic [31:0] DEV_PX_SACT   = 32'h0002_0034;
	localparam logic [31:0] DEV_PX_CI     = 32'h0002_0038;
	// ------------------------------------------------------------
	// operations, command codes and fields
	// ------------------------------------------------------------
	localparam logic [2:0]  OP_IDENTIFY = 3'h0;
	localparam logic [2:0]  OP_WR_DMA   = 3'h1;
	localparam logic [2:0]  OP_RD_DMA   = 3'h2;
	localparam logic [2:0]  OP_WR_FPDMA = 3'h3;
	localparam logic [2:0]  OP_RD_FPDMA = 3'h4;
	localparam logic [7:0]  CMD_IDENTIFY = 8'hEC;
	localparam logic [7:0]  CMD_WR_DMA   = 8'h35;
	localparam logic [7:0]  CMD_RD_DMA   = 8'h25;
	localparam logic [7:0]  CMD_WR_FPDMA = 8'h61;
	localparam logic [7:0]  CMD_RD_FPDMA = 8'h60;
	localparam logic [7:0]  DEV_IDENTIFY = 8'hA0;
	localparam logic [7:0]  DEV_DMA      = 8'hE0;
	localparam logic [7:0]  FIS_H2D_TYPE = 8'h27;
	localparam int          FIS_C_BIT    = 15;
	localparam logic [2:0]  FIS_DWORDS   = 3'h5;
	localparam logic [15:0] HDR_PRDTL    = 16'h0001;
	localparam logic [4:0]  HDR_CFL      = 5'h05;
	localparam int          HDR_W_BIT    = 6;
	localparam int          PRD_I_BIT    = 31;
	localparam logic [21:0] IDENT_BYTES  = 22'h00_01FF;
	// port interrupt status bit positions
	localparam int          IS_DHRS = 0;
	localparam int          IS_PSS  = 1;
	localparam int          IS_DSS  = 2;
	localparam int          IS_SDBS = 3;
	localparam int          IS_DPS  = 5;
	// status register bit positions
	localparam int          ST_BUSY = 0;
	localparam int          ST_DONE = 1;
	localparam int          ST_ERR  = 2;
	typedef enum {
		ST_IDLE, ST_SACT_RD, ST_SACT_WR, ST_HDR, ST_FIS, ST_PRD_ADDR,
		ST_PRD_CNT, ST_ISSUE, ST_IS_RD, ST_IS_CLR, ST_CI_RD, ST_SACT_CHK
	} ahpc_state_t;
endpackage

// file: design/ahpc_host.sv
// module: host controller that runs commands on one command-flow port
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - command header dword 0 gets the prd count; one prd for identify.
// - each command writes a five-dword register fis, type 27h, c bit set.
// - identify uses code ECh, device A0h, all other fields zero.
// - prd holds base address, interrupt bit, zero-based count; 0x1FF.
// - writing one to command-issue bit n sends slot n's fis.
// - port status bits clear by writing one to them.
// - dma write uses 35h, device E0h, 48-bit lba, 16-bit count.
// - one prd per segment; last prd carries the interrupt bit.
// - dma read uses 25h with the same preparation and issue flow.
// - queued: read sata-active, pick free slot, set its bit; here software names the slot and a taken slot ends in error.
// - up to 32 queued commands, fill and data phases concurrent; this controller runs one command at a time.
// - queued read follows queued write with receive buffers.
// - queued write and read use codes 61h and 60h.
// - queued fis tag field equals the slot number, 0 to 31.
module ahpc_host
	import ahpc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic [31:0] m_paddr,
	output var  logic        m_psel,
	output var  logic        m_penable,
	output var  logic        m_pwrite,
	output var  logic [31:0] m_pwdata,
	input  wire logic [31:0] m_prdata,
	input  wire logic        m_pready,
	input  wire logic        m_pslverr
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ahpc_state_t state, next_state;
	logic [2:0]  op, next_op;
	logic [4:0]  slot, next_slot;
	logic [47:0] lba, next_lba;
	logic [15:0] count, next_count;
	logic [31:0] buf_addr, next_buf_addr;
	logic [21:0] byte_cnt, next_byte_cnt;
	logic        busy, next_busy;
	logic        done, next_done;
	logic        err, next_err;
	logic [5:0]  seen, next_seen;
	logic [5:0]  clr, next_clr;
	logic [2:0]  idx, next_idx;
	logic [31:0] next_prdata;
	logic        next_pready, next_pslverr;
	logic [31:0] next_m_paddr, next_m_pwdata;
	logic        next_m_psel, next_m_penable, next_m_pwrite;
	// combinational helpers
	logic        queued, sw_wr, done_xfer, start;
	logic [5:0]  expect_bits;
	logic [7:0]  code, devf;
	logic [31:0] slot_bit, hdr_addr, tbl_addr, x_addr, x_data;
	logic        x_wr;

	assign queued    = (op == OP_WR_FPDMA) || (op == OP_RD_FPDMA);
	assign slot_bit  = 32'h0000_0001 << slot;
	assign hdr_addr  = DEV_HDR_BASE + ({27'h000_0000, slot} << DEV_HDR_SHIFT);
	assign tbl_addr  = DEV_TBL_BASE + ({27'h000_0000, slot} << DEV_TBL_SHIFT);
	assign done_xfer = m_psel && m_penable && m_pready;
	assign sw_wr     = psel && penable && pwrite;
	assign start     = sw_wr && (paddr == REG_CTRL) && pwdata[0] && !busy;

	// ------------------------------------------------------------
	// command fields per operation
	// ------------------------------------------------------------
	always_comb begin
		case (op)
		OP_IDENTIFY: begin
			code = CMD_IDENTIFY;
			devf = DEV_IDENTIFY;
			expect_bits = 6'h00;
			expect_bits[IS_PSS] = 1'b1;
			expect_bits[IS_DPS] = 1'b1;
		end
		OP_WR_DMA, OP_RD_DMA: begin
			code = (op == OP_WR_DMA) ? CMD_WR_DMA : CMD_RD_DMA;
			devf = DEV_DMA;
			expect_bits = 6'h00;
			expect_bits[IS_DHRS] = 1'b1;
			expect_bits[IS_DPS] = 1'b1;
		end
		default: begin
			code = (op == OP_WR_FPDMA) ? CMD_WR_FPDMA : CMD_RD_FPDMA;
			devf = DEV_DMA;
			expect_bits = 6'h00;
			expect_bits[IS_DHRS] = 1'b1;
			expect_bits[IS_DSS] = 1'b1;
			expect_bits[IS_DPS] = 1'b1;
			expect_bits[IS_SDBS] = 1'b1;
		end
		endcase
	end

	// ------------------------------------------------------------
	// device access selected by the sequence step
	// ------------------------------------------------------------
	always_comb begin
		x_addr = DEV_PX_IS;
		x_data = 32'h0000_0000;
		x_wr   = 1'b0;
		case (state)
		ST_SACT_RD, ST_SACT_CHK: x_addr = DEV_PX_SACT;
		ST_SACT_WR: begin
			x_addr = DEV_PX_SACT;
			x_data = slot_bit;
			x_wr   = 1'b1;
		end
		ST_HDR: begin
			x_addr = hdr_addr;
			x_data = {HDR_PRDTL, 16'h0000} | {27'h000_0000, HDR_CFL};
			x_data[HDR_W_BIT] = (op == OP_WR_DMA) || (op == OP_WR_FPDMA);
			x_wr   = 1'b1;
		end
		ST_FIS: begin
			x_addr = tbl_addr + {27'h000_0000, idx, 2'b00};
			x_wr   = 1'b1;
			case (idx)
			3'h0: begin
				x_data = {queued ? count[7:0] : 8'h00, code, 8'h00, FIS_H2D_TYPE};
				x_data[FIS_C_BIT] = 1'b1;
			end
			3'h1: x_data = (op == OP_IDENTIFY) ? {devf, 24'h00_0000}
				: {devf, lba[23:0]};
			3'h2: x_data = (op == OP_IDENTIFY) ? 32'h0000_0000
				: {queued ? count[15:8] : 8'h00, lba[47:24]};
			3'h3: x_data = (op == OP_IDENTIFY) ? 32'h0000_0000
				: queued ? {24'h00_0000, slot, 3'h0}
				: {16'h0000, count};
			default: x_data = 32'h0000_0000;
			endcase
		end
		ST_PRD_ADDR: begin
			x_addr = tbl_addr + DEV_PRD_OFS;
			x_data = buf_addr;
			x_wr   = 1'b1;
		end
		ST_PRD_CNT: begin
			// single segment, so it is also the last and carries the irq bit
			x_addr = tbl_addr + DEV_PRD_OFS + 32'h0000_000C;
			x_data = {10'h000, byte_cnt};
			x_data[PRD_I_BIT] = 1'b1;
			x_wr   = 1'b1;
		end
		ST_ISSUE: begin
			x_addr = DEV_PX_CI;
			x_data = slot_bit;
			x_wr   = 1'b1;
		end
		ST_IS_CLR: begin
			x_data = {26'h000_0000, clr};
			x_wr   = 1'b1;
		end
		ST_CI_RD: x_addr = DEV_PX_CI;
		default: ;
		endcase
	end

	// ------------------------------------------------------------
	// next values: software registers, sequencer, bus master
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;     next_op = op;         next_slot = slot;
		next_lba = lba;         next_count = count;   next_buf_addr = buf_addr;
		next_byte_cnt = byte_cnt; next_busy = busy;   next_done = done;
		next_err = err;         next_seen = seen;     next_clr = clr;
		next_idx = idx;
		next_m_psel = m_psel;   next_m_penable = m_penable;
		next_m_paddr = m_paddr; next_m_pwdata = m_pwdata;
		next_m_pwrite = m_pwrite;
		// apb slave, zero wait states, answer registered from setup
		next_pready = psel && !penable;
		next_pslverr = 1'b0;
		next_prdata = 32'h0000_0000;
		if (psel && !penable) begin
			case (paddr)
			REG_CTRL:     next_prdata = {23'h00_0000, slot, op, 1'b0};
			REG_LBA_LO:   next_prdata = lba[31:0];
			REG_LBA_HI:   next_prdata = {16'h0000, lba[47:32]};
			REG_COUNT:    next_prdata = {16'h0000, count};
			REG_BUF_ADDR: next_prdata = buf_addr;
			REG_BYTE_CNT: next_prdata = {10'h000, byte_cnt};
			REG_STATUS:   next_prdata = {18'h0_0000, 2'b00, seen, 3'h0, err, done, busy};
			default:      next_pslverr = 1'b1;
			endcase
		end
		// parameters are locked while a command runs
		if (sw_wr && !busy) begin
			case (paddr)
			REG_CTRL: begin
				next_slot = pwdata[8:4];
				next_op = pwdata[3:1];
			end
			REG_LBA_LO:   next_lba[31:0] = pwdata;
			REG_LBA_HI:   next_lba[47:32] = pwdata[15:0];
			REG_COUNT:    next_count = pwdata[15:0];
			REG_BUF_ADDR: next_buf_addr = pwdata;
			REG_BYTE_CNT: next_byte_cnt = pwdata[21:0];
			default: ;
			endcase
		end
		// done is write-one-to-clear; a finish in the same cycle wins below
		if (sw_wr && (paddr == REG_STATUS) && pwdata[ST_DONE])
			next_done = 1'b0;
		if (start) begin
			next_busy = 1'b1;
			next_err = 1'b0;
			next_seen = 6'h00;
			next_idx = 3'h0;
			next_state = (pwdata[3:1] == OP_WR_FPDMA) || (pwdata[3:1] == OP_RD_FPDMA)
				? ST_SACT_RD : ST_HDR;
			// identify always moves one 512-byte block
			if (pwdata[3:1] == OP_IDENTIFY)
				next_byte_cnt = IDENT_BYTES;
		end
		// one apb transfer per step; request held until pready is seen
		if (state != ST_IDLE) begin
			if (!m_psel) begin
				next_m_psel = 1'b1;
				next_m_paddr = x_addr;
				next_m_pwdata = x_data;
				next_m_pwrite = x_wr;
			end else if (!m_penable) begin
				next_m_penable = 1'b1;
			end else if (m_pready) begin
				next_m_psel = 1'b0;
				next_m_penable = 1'b0;
				if (m_pslverr) begin
					next_err = 1'b1;
					next_state = ST_IDLE;
				end else begin
					case (state)
					ST_SACT_RD: begin
						// slot already reserved: refuse rather than collide
						if ((m_prdata & slot_bit) != 32'h0000_0000) begin
							next_err = 1'b1;
							next_state = ST_IDLE;
						end else
							next_state = ST_SACT_WR;
					end
					ST_SACT_WR:  next_state = ST_HDR;
					ST_HDR:      next_state = ST_FIS;
					ST_FIS: begin
						next_idx = idx + 3'h1;
						if (idx == FIS_DWORDS - 3'h1)
							next_state = ST_PRD_ADDR;
					end
					ST_PRD_ADDR: next_state = ST_PRD_CNT;
					ST_PRD_CNT:  next_state = ST_ISSUE;
					ST_ISSUE:    next_state = ST_IS_RD;
					ST_IS_RD: begin
						next_clr = m_prdata[5:0] & expect_bits;
						if ((m_prdata[5:0] & expect_bits) != 6'h00)
							next_state = ST_IS_CLR;
					end
					ST_IS_CLR: begin
						next_seen = seen | clr;
						next_state = ((seen | clr) == expect_bits)
							? ST_CI_RD : ST_IS_RD;
					end
					ST_CI_RD: begin
						if ((m_prdata & slot_bit) == 32'h0000_0000)
							next_state = queued ? ST_SACT_CHK : ST_IDLE;
					end
					ST_SACT_CHK: begin
						if ((m_prdata & slot_bit) == 32'h0000_0000)
							next_state = ST_IDLE;
					end
					default: next_state = ST_IDLE;
					endcase
				end
				if (next_state == ST_IDLE) begin
					next_busy = 1'b0;
					next_done = 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;     op <= OP_IDENTIFY;     slot <= 5'h00;
			lba <= 48'h0000_0000_0000; count <= 16'h0000;
			buf_addr <= 32'h0000_0000; byte_cnt <= 22'h00_0000;
			busy <= 1'b0;         done <= 1'b0;          err <= 1'b0;
			seen <= 6'h00;        clr <= 6'h00;          idx <= 3'h0;
			prdata <= 32'h0000_0000; pready <= 1'b0;     pslverr <= 1'b0;
			m_paddr <= 32'h0000_0000; m_pwdata <= 32'h0000_0000;
			m_psel <= 1'b0;       m_penable <= 1'b0;     m_pwrite <= 1'b0;
		end else begin
			state <= next_state;  op <= next_op;         slot <= next_slot;
			lba <= next_lba;      count <= next_count;
			buf_addr <= next_buf_addr; byte_cnt <= next_byte_cnt;
			busy <= next_busy;    done <= next_done;     err <= next_err;
			seen <= next_seen;    clr <= next_clr;       idx <= next_idx;
			prdata <= next_prdata; pready <= next_pready;
			pslverr <= next_pslverr;
			m_paddr <= next_m_paddr; m_pwdata <= next_m_pwdata;
			m_psel <= next_m_psel; m_penable <= next_m_penable;
			m_pwrite <= next_m_pwrite;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	issue_write_a: assert property (done_xfer && state == ST_ISSUE |->
		m_pwrite && m_paddr == DEV_PX_CI && m_pwdata == slot_bit)
		else $error("issue write wrong");
	fis_header_a: assert property (done_xfer && state == ST_FIS && idx == 3'h0
		|-> m_pwdata[7:0] == FIS_H2D_TYPE && m_pwdata[FIS_C_BIT]
		&& m_pwdata[23:16] == code)
		else $error("fis dword 0 wrong");
	prd_count_a: assert property (done_xfer && state == ST_PRD_CNT |->
		m_pwdata[PRD_I_BIT] && m_pwdata[21:0] == byte_cnt)
		else $error("prd count dword wrong");
	hdr_prdtl_a: assert property (done_xfer && state == ST_HDR |->
		m_pwdata[31:16] == HDR_PRDTL)
		else $error("prd table length wrong");
	clear_mask_a: assert property (done_xfer && state == ST_IS_CLR |->
		m_pwdata[5:0] != 6'h00 && m_pwdata[5:0] == clr
		&& (clr & ~expect_bits) == 6'h00)
		else $error("status clear wrong");
	queued_tag_a: assert property (done_xfer && state == ST_FIS && idx == 3'h3
		&& queued |-> m_pwdata[7:3] == slot)
		else $error("queued tag wrong");
	reserve_first_a: assert property (state == ST_HDR && $past(state) != ST_HDR
		&& queued |-> $past(state) == ST_SACT_WR)
		else $error("slot not reserved first");
	ci_clear_a: assert property (done_xfer && state == ST_CI_RD
		&& m_prdata[slot] && !m_pslverr |=> state == ST_CI_RD)
		else $error("left before issue bit cleared");
	master_hold_a: assert property (m_psel && m_penable && !m_pready |=>
		$stable(m_paddr) && $stable(m_pwdata) && $stable(m_pwrite) && m_psel)
		else $error("request changed before pready");
	done_pulse_a: assert property (busy && !next_busy |=> done && !busy)
		else $error("done not raised at finish");

	identify_c: cover property (start && pwdata[3:1] == OP_IDENTIFY ##[1:300]
		done && !busy);
	queued_c: cover property (state == ST_SACT_CHK ##1 state == ST_IDLE);
	refuse_c: cover property (state == ST_SACT_RD ##1 err);
endmodule
`default_nettype wire

// file: tb/ahpc_dev_model.sv
// device-side port model: command memories, status, issue and active slots
`timescale 1ns/1ps
`default_nettype none
module ahpc_dev_model
	import ahpc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [31:0] m_paddr,
	input  wire logic        m_psel,
	input  wire logic        m_penable,
	input  wire logic        m_pwrite,
	input  wire logic [31:0] m_pwdata,
	output var  logic [31:0] m_prdata,
	output var  logic        m_pready,
	output var  logic        m_pslverr,
	input  wire logic [3:0]  slow,
	input  wire logic        fail,
	input  wire logic [31:0] resv
);
	logic [31:0] mem [logic [31:0]];
	logic [31:0] is_r;
	logic [31:0] sact;
	logic [31:0] ci;
	logic [7:0]  code;
	logic [4:0]  slot;
	int          wait_n;
	int          run_n;
	int          free_n;

	function automatic logic [31:0] rd_word(input logic [31:0] a);
		case (a)
			DEV_PX_IS:   return is_r;
			DEV_PX_SACT: return sact | resv;
			DEV_PX_CI:   return ci;
			default:     return mem.exists(a) ? mem[a] : 32'h0000_0000;
		endcase
	endfunction

	task automatic wr_word(input logic [31:0] a, input logic [31:0] d);
		case (a)
			DEV_PX_IS:   is_r &= ~d;
			DEV_PX_SACT: sact |= d;
			DEV_PX_CI: begin
				ci |= d;
				for (int i = 31; i >= 0; i--) begin
					if (d[i]) slot = 5'(i);
				end
				// the command code of the issued slot picks the reply pattern
				code = mem[DEV_TBL_BASE + (32'(slot) << DEV_TBL_SHIFT)][23:16];
				run_n = 4 + 3 * int'(slow);
			end
			default: mem[a] = d;
		endcase
	endtask

	// ------------------------------------------------------------
	// bus answer and command progress
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m_prdata <= 32'h0000_0000;
			m_pready <= 1'b0;
			m_pslverr <= 1'b0;
			is_r = '0;
			sact = '0;
			ci = '0;
			wait_n = 0;
			run_n = 0;
			free_n = 0;
		end else begin
			m_pready <= 1'b0;
			m_pslverr <= 1'b0;
			// an idle bus inverts the last value every cycle instead of holding it
			m_prdata <= ~m_prdata;
			if (m_psel && m_penable && m_pready) begin
				if (m_pwrite) wr_word(m_paddr, m_pwdata);
			end else if (m_psel && m_penable) begin
				if (wait_n < int'(slow)) begin
					wait_n++;
				end else begin
					wait_n = 0;
					m_pready <= 1'b1;
					m_pslverr <= fail;
					m_prdata <= rd_word(m_paddr);
				end
			end
			if (run_n > 0) begin
				run_n--;
				if (run_n == 0) begin
					case (code)
						CMD_IDENTIFY: is_r |= 32'h1 << IS_PSS | 32'h1 << IS_DPS;
						CMD_WR_DMA, CMD_RD_DMA: is_r |= 32'h1 << IS_DHRS | 32'h1 << IS_DPS;
						default: begin
							is_r |= 32'h1 << IS_DHRS | 32'h1 << IS_DSS;
							is_r |= 32'h1 << IS_DPS | 32'h1 << IS_SDBS;
							free_n = 3;
						end
					endcase
					ci[slot] = 1'b0;
				end
			end
			if (free_n > 0) begin
				free_n--;
				if (free_n == 0) sact[slot] = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/ahci_port_command_flow_test.sv
// self-checking bench for the port command-flow host controller
`timescale 1ns/1ps
`default_nettype none
module ahci_port_command_flow_test
	import ahpc_pkg::*;
;
	logic        pclk;
	logic        presetn;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] m_paddr;
	logic        m_psel;
	logic        m_penable;
	logic        m_pwrite;
	logic [31:0] m_pwdata;
	logic [31:0] m_prdata;
	logic        m_pready;
	logic        m_pslverr;
	logic [3:0]  slow;
	logic        fail;
	logic [31:0] resv;
	logic [31:0] st;
	logic        e;
	int          n_mismatch;
	int          checks;
	logic [7:0]  codes [5] = '{CMD_IDENTIFY, CMD_WR_DMA, CMD_RD_DMA,
		CMD_WR_FPDMA, CMD_RD_FPDMA};
	logic [4:0]  slots [5] = '{5'd0, 5'd0, 5'd0, 5'd31, 5'd5};

	ahpc_host DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .m_paddr(m_paddr), .m_psel(m_psel),
		.m_penable(m_penable), .m_pwrite(m_pwrite), .m_pwdata(m_pwdata),
		.m_prdata(m_prdata), .m_pready(m_pready), .m_pslverr(m_pslverr));
	ahpc_dev_model dev (.pclk(pclk), .presetn(presetn), .m_paddr(m_paddr),
		.m_psel(m_psel), .m_penable(m_penable), .m_pwrite(m_pwrite),
		.m_pwdata(m_pwdata), .m_prdata(m_prdata), .m_pready(m_pready),
		.m_pslverr(m_pslverr), .slow(slow), .fail(fail), .resv(resv));

	always #4 pclk = ~pclk;

	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        err;
		apb(1'b1, a, d, q, err);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic err;
		apb(1'b0, a, 32'h0000_0000, q, err);
	endtask

	// one command from parameter setup to the finished status
	task automatic go(input logic [2:0] op, input logic [4:0] s, input logic err);
		logic [47:0] lba;
		logic [15:0] cnt;
		logic [15:0] ft;
		logic [31:0] t;
		logic [31:0] h;
		logic [31:0] r;
		logic        q;
		logic        w;
		logic [5:0]  eb;
		int          n;
		lba = 48'h0A1B_2C3D_4E5F + 48'(op);
		cnt = 16'h0102 + 16'(s);
		q = op >= OP_WR_FPDMA;
		w = op == OP_WR_DMA || op == OP_WR_FPDMA;
		// port status bits that the command must have cleared on its way
		eb = op == OP_IDENTIFY ? 6'h22 : q ? 6'h2D : 6'h21;
		ft = q ? cnt : 16'h0000;
		t = DEV_TBL_BASE + (32'(s) << DEV_TBL_SHIFT);
		h = DEV_HDR_BASE + (32'(s) << DEV_HDR_SHIFT);
		wr(REG_LBA_LO, lba[31:0]);
		wr(REG_LBA_HI, {16'h0000, lba[47:32]});
		wr(REG_COUNT, {16'h0000, cnt});
		wr(REG_BUF_ADDR, 32'h8000_0000 + 32'(s));
		wr(REG_BYTE_CNT, 32'h0000_0FFF);
		wr(REG_CTRL, {23'h00_0000, s, op, 1'b1});
		// parameters are locked while busy, so this must not reach the prd
		wr(REG_BUF_ADDR, 32'h0000_0BAD);
		n = 0;
		do begin
			rd(REG_STATUS, r);
			n++;
		end while (r[ST_BUSY] !== 1'b0 && n < 500);
		check({29'h0, r[2:0]}, {29'h0, err, 2'b10}, "status");
		check({26'h0, r[11:6]}, {26'h0, err ? 6'h00 : eb}, "seen");
		if (!err) begin
			check(dev.mem[h], 32'h0001_0005 | {25'h0, w, 6'h0}, "hdr");
			check(dev.mem[t], {ft[7:0], codes[op], 8'h80, FIS_H2D_TYPE}, "fis0");
			check(dev.mem[t + 4], op == OP_IDENTIFY ? 32'hA000_0000 :
				{DEV_DMA, lba[23:0]}, "fis1");
			check(dev.mem[t + 8], op == OP_IDENTIFY ? 32'h0000_0000 :
				{ft[15:8], lba[47:24]}, "fis2");
			check(dev.mem[t + 12], op == OP_IDENTIFY ? 32'h0000_0000 :
				q ? {24'h00_0000, s, 3'b000} : {16'h0000, cnt}, "fis3");
			check(dev.mem[t + 16], 32'h0000_0000, "fis4");
			check(dev.mem[t + DEV_PRD_OFS], 32'h8000_0000 + 32'(s), "prd0");
			check(dev.mem[t + DEV_PRD_OFS + 12], {1'b1, 9'h000,
				op == OP_IDENTIFY ? 22'h00_01FF : 22'h00_0FFF}, "prd3");
			check(dev.is_r, 32'h0000_0000, "port status left");
			check(dev.ci | dev.sact, 32'h0000_0000, "slot busy");
		end
		wr(REG_STATUS, 32'h0000_0002);
		rd(REG_STATUS, r);
		check({31'h0, r[ST_DONE]}, 32'h0000_0000, "done clear");
		$display("test op %0d slot %0d ended", op, s);
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		slow = 4'h0;
		fail = 1'b0;
		resv = 32'h0000_0000;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(REG_STATUS, st);
		check(st, 32'h0000_0000, "status reset");
		apb(1'b0, 8'h3C, 32'h0000_0000, st, e);
		check({31'h0, e}, 32'h0000_0001, "unmapped error");
		check(st, 32'h0000_0000, "unmapped data");
		$display("test registers ended");
		for (int i = 0; i < 5; i++) begin
			slow <= 4'(i);
			go(3'(i), slots[i], 1'b0);
		end
		go(OP_WR_FPDMA, 5'd0, 1'b0);
		// a reserved slot must not be taken again
		resv <= 32'h0000_0080;
		go(OP_RD_FPDMA, 5'd7, 1'b1);
		resv <= 32'h0000_0000;
		fail <= 1'b1;
		go(OP_WR_DMA, 5'd2, 1'b1);
		fail <= 1'b0;
		go(OP_IDENTIFY, 5'd1, 1'b0);
		test_done();
	end

	initial begin
		repeat (40000) @(posedge pclk);
		n_mismatch++;
		$display("BAD t=%0t watchdog expired", $time);
		test_done();
	end
endmodule
`default_nettype wire
